/* logic/bpg_supervisor.sv */
// Fault and power-good supervisor of a synchronous buck controller
// Function
// - Window is +-10% of reference, before protection
// - Power-good low from reset until ramp done
// - Release at ramp end if in window
// - Overcurrent drops power-good until cleared
// - Protection latches never drive power-good directly
// - Latching variant: overcurrent latches both drives low
// - Retry variant: off, wait 10 ms, restart
// - Overvoltage: high side low, low side hysteretic
// - Open sense input counts as overvoltage
// - Fixed 300 or 600 kHz period
// - Duty limit 85% low, 75% high frequency
// - Undervoltage after ramp latches off until reset
module bpg_supervisor #(
    parameter bit FREQ_HIGH = 1'b0,
    parameter bit OC_RETRY = 1'b0,
    parameter bit UV_ENABLE = 1'b1,
    parameter int RETRY_CYCLES = bpg_pkg::RETRY_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic senseWinLowIn,
    input wire logic senseWinHighIn,
    input wire logic undervoltageTripIn,
    input wire logic overvoltageTripIn,
    input wire logic senseBelowHalfIn,
    input wire logic overcurrentTripIn,
    input wire logic senseOpenIn,
    input wire logic softStartDoneIn,
    input wire logic enableIn,
    output logic powerGoodOut,
    output logic powerGoodOe_n,
    output logic highSideDrive,
    output logic lowSideDrive,
    output logic softStartRun,
    output logic irq
);

    // ------------------------------------------------------------
    // Variant constants
    // ------------------------------------------------------------
    localparam int PER = FREQ_HIGH ? bpg_pkg::PER_HI_CYC
                                   : bpg_pkg::PER_LO_CYC;
    localparam int MAXON = FREQ_HIGH ? bpg_pkg::MAXON_HI_CYC
                                     : bpg_pkg::MAXON_LO_CYC;
    localparam logic [bpg_pkg::RETRY_W-1:0] RETRY_LAST =
        bpg_pkg::RETRY_W'(RETRY_CYCLES - 1);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    bpg_pkg::bpg_flags_t rawFlags;
    bpg_pkg::bpg_flags_t flags;

    assign rawFlags = '{winLow: senseWinLowIn, winHigh: senseWinHighIn,
                        uvTrip: undervoltageTripIn,
                        ovTrip: overvoltageTripIn,
                        ovBelowHalf: senseBelowHalfIn,
                        ocTrip: overcurrentTripIn,
                        senseOpen: senseOpenIn,
                        ssDone: softStartDoneIn, enable: enableIn};

    bpg_sync #(.W(bpg_pkg::SYNC_W)) uSync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn(rawFlags),
        .syncOut(flags)
    );

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    bpg_pkg::bpg_state_t state_r;
    bpg_pkg::bpg_state_t state_nxt;
    logic ssPrev_r;
    logic ssRise;
    logic ovCond;
    logic ocHit;
    logic [bpg_pkg::RETRY_W-1:0] waitCnt_r;
    logic ocPgLow_r;
    logic pgRel_r;
    logic rampOk_r;
    logic pgAllow;
    logic ovLsOn_r;
    logic pwmHigh;
    logic [7:0] duty_r;
    logic [4:0] intStat_r;
    logic [4:0] intMask_r;
    logic [4:0] events;
    bpg_pkg::bpg_gate_t gate_r;

    assign ssRise = flags.ssDone && !ssPrev_r;
    // Open sense pin is treated exactly like an overvoltage
    assign ovCond = flags.ovTrip || flags.senseOpen;
    assign ocHit = flags.ocTrip &&
        (state_r == bpg_pkg::ST_SOFT || state_r == bpg_pkg::ST_RUN);

    // Edge memory for the ramp-done flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ssPrev_r <= 1'b0;
        end else begin
            ssPrev_r <= flags.ssDone;
        end
    end

    // Next state; overvoltage outranks everything, voltage latches hold
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bpg_pkg::ST_IDLE: begin
                if (flags.enable) begin
                    state_nxt = bpg_pkg::ST_SOFT;
                end
            end
            bpg_pkg::ST_SOFT: begin
                if (ocHit) begin
                    state_nxt = OC_RETRY ? bpg_pkg::ST_OCWAIT
                                         : bpg_pkg::ST_OCLATCH;
                end else if (ssRise) begin
                    state_nxt = bpg_pkg::ST_RUN;
                end
            end
            bpg_pkg::ST_RUN: begin
                if (ocHit) begin
                    state_nxt = OC_RETRY ? bpg_pkg::ST_OCWAIT
                                         : bpg_pkg::ST_OCLATCH;
                end else if (UV_ENABLE && flags.uvTrip) begin
                    state_nxt = bpg_pkg::ST_UVLATCH;
                end
            end
            bpg_pkg::ST_OCWAIT: begin
                if (waitCnt_r == RETRY_LAST) begin
                    state_nxt = bpg_pkg::ST_SOFT;
                end
            end
            default: begin
                state_nxt = state_r;
            end
        endcase
        // Enable low stops the output, but not the voltage latches
        if (!flags.enable && state_r != bpg_pkg::ST_UVLATCH &&
            state_r != bpg_pkg::ST_OVLATCH) begin
            state_nxt = bpg_pkg::ST_IDLE;
        end
        if (ovCond) begin
            state_nxt = bpg_pkg::ST_OVLATCH;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= bpg_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Retry delay counter; restarts on every entry to the wait
    always_ff @(posedge ref_clk) begin
        if (!rst_n || state_r != bpg_pkg::ST_OCWAIT) begin
            waitCnt_r <= '0;
        end else begin
            waitCnt_r <= waitCnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Power-good
    // ------------------------------------------------------------
    // Overcurrent mark; a trip in the clearing cycle still sets it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ocPgLow_r <= 1'b0;
        end else if (ocHit) begin
            ocPgLow_r <= 1'b1;
        end else if (!flags.enable ||
                     (state_r == bpg_pkg::ST_SOFT && ssRise)) begin
            ocPgLow_r <= 1'b0;
        end
    end

    // Once ramped, a voltage latch leaves power-good to the window
    assign pgAllow = (state_r == bpg_pkg::ST_RUN) || (rampOk_r &&
        (state_r == bpg_pkg::ST_UVLATCH || state_r == bpg_pkg::ST_OVLATCH));

    // Only window, ramp progress and overcurrent steer power-good
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pgRel_r <= 1'b0;
            rampOk_r <= 1'b0;
        end else begin
            rampOk_r <= pgAllow;
            pgRel_r <= pgAllow &&
                       !flags.winLow && !flags.winHigh &&
                       !ocPgLow_r && !flags.ocTrip;
        end
    end

    // Open-drain pin: data is always low, powerGoodOe_n high releases it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            powerGoodOut <= 1'b0;
            powerGoodOe_n <= 1'b0;
        end else begin
            powerGoodOut <= 1'b0;
            powerGoodOe_n <= pgRel_r;
        end
    end

    // ------------------------------------------------------------
    // Gate drives
    // ------------------------------------------------------------
    bpg_pwm #(.PER(PER), .MAXON(MAXON)) uPwm (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(state_r == bpg_pkg::ST_SOFT || state_r == bpg_pkg::ST_RUN),
        .dutyCmd(duty_r),
        .pwmHigh(pwmHigh)
    );

    // Low-side hysteresis during overvoltage: on at 125%, off at 50%
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ovLsOn_r <= 1'b0;
        end else if (ovCond) begin
            ovLsOn_r <= 1'b1;
        end else if (flags.ovBelowHalf) begin
            ovLsOn_r <= 1'b0;
        end
    end

    // Drives are registered; latches force both or the high side low
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gate_r <= '0;
        end else begin
            case (state_r)
                bpg_pkg::ST_SOFT, bpg_pkg::ST_RUN: begin
                    gate_r <= '{highSide: pwmHigh, lowSide: !pwmHigh};
                end
                bpg_pkg::ST_OVLATCH: begin
                    gate_r <= '{highSide: 1'b0, lowSide: ovLsOn_r};
                end
                default: begin
                    gate_r <= '0;
                end
            endcase
        end
    end

    assign highSideDrive = gate_r.highSide;
    assign lowSideDrive = gate_r.lowSide;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            softStartRun <= 1'b0;
        end else begin
            softStartRun <= (state_nxt == bpg_pkg::ST_SOFT);
        end
    end

    // ------------------------------------------------------------
    // Interrupts and registers
    // ------------------------------------------------------------
    // One bit per status event, in status-register order
    assign events = {ssRise && state_r == bpg_pkg::ST_SOFT,
                     powerGoodOe_n && !pgRel_r,
                     ovCond && state_r != bpg_pkg::ST_OVLATCH,
                     state_nxt == bpg_pkg::ST_UVLATCH &&
                         state_r != bpg_pkg::ST_UVLATCH,
                     ocHit};

    // Sticky status; a new event beats a write-one clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            intStat_r <= '0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (events[i]) begin
                    intStat_r[i] <= 1'b1;
                end else if (regWr && regAddr == bpg_pkg::REG_INT_STAT &&
                             regWdata[i]) begin
                    intStat_r[i] <= 1'b0;
                end
            end
        end
    end

    // Writable control and mask
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            duty_r <= bpg_pkg::DUTY_RST;
            intMask_r <= bpg_pkg::MASK_RST;
        end else if (regWr) begin
            if (regAddr == bpg_pkg::REG_CTRL) begin
                duty_r <= regWdata[7:0];
            end else if (regAddr == bpg_pkg::REG_INT_MASK) begin
                intMask_r <= regWdata[4:0];
            end
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !regRd) begin
            regRdata <= 32'h00000000;
        end else if (regAddr == bpg_pkg::REG_CTRL) begin
            regRdata <= {24'h000000, duty_r};
        end else if (regAddr == bpg_pkg::REG_STATE) begin
            regRdata <= {22'h000000, ocPgLow_r, pgRel_r, ovLsOn_r,
                         state_r};
        end else if (regAddr == bpg_pkg::REG_INT_STAT) begin
            regRdata <= {27'h0000000, intStat_r};
        end else if (regAddr == bpg_pkg::REG_INT_MASK) begin
            regRdata <= {27'h0000000, intMask_r};
        end else if (regAddr == bpg_pkg::REG_VARIANT) begin
            regRdata <= {29'h00000000, UV_ENABLE, OC_RETRY, FREQ_HIGH};
        end else begin
            regRdata <= 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStat_r & intMask_r);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence ovEntry;
        ovCond ##1 (state_r == bpg_pkg::ST_OVLATCH);
    endsequence

    pg_hold_low_a: assert property (
        !(state_r inside {bpg_pkg::ST_RUN, bpg_pkg::ST_UVLATCH,
                          bpg_pkg::ST_OVLATCH}) |=> ##1 !powerGoodOe_n)
        else $error("power-good released outside run");

    pg_window_a: assert property (
        (flags.winLow || flags.winHigh) |=> ##1 !powerGoodOe_n)
        else $error("power-good high out of window");

    pg_release_a: assert property (
        (state_r == bpg_pkg::ST_RUN && !flags.winLow && !flags.winHigh &&
         !ocPgLow_r && !flags.ocTrip) |=> ##1 powerGoodOe_n)
        else $error("power-good not released in window");

    oc_latch_off_a: assert property (
        (state_r == bpg_pkg::ST_OCLATCH) |=> !highSideDrive && !lowSideDrive)
        else $error("drives active in overcurrent latch");

    retry_wait_a: assert property (
        $rose(state_r == bpg_pkg::ST_OCWAIT) |->
            (state_r == bpg_pkg::ST_OCWAIT)[*8])
        else $error("retry wait ended early");

    ov_drive_a: assert property (
        ovEntry ##1 ovCond |=> ##1 (!highSideDrive && lowSideDrive))
        else $error("overvoltage drive pattern wrong");

    sense_open_a: assert property (
        flags.senseOpen |=> state_r == bpg_pkg::ST_OVLATCH)
        else $error("open sense not taken as overvoltage");

    uv_sticky_a: assert property (
        (state_r == bpg_pkg::ST_UVLATCH && !ovCond) |=>
            state_r == bpg_pkg::ST_UVLATCH && !highSideDrive)
        else $error("undervoltage latch released");

    oc_pg_low_a: assert property (
        ocHit |=> ##1 !powerGoodOe_n)
        else $error("overcurrent left power-good high");

endmodule

/* include/bpg_pkg.sv */
// Constants, types and register map of the buck power-good logic
package bpg_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int SW_LO_HZ = 300_000;
    localparam int SW_HI_HZ = 600_000;
    localparam int PER_LO_CYC = CLK_HZ / SW_LO_HZ;
    localparam int PER_HI_CYC = CLK_HZ / SW_HI_HZ;
    localparam int MAXD_LO_PCT = 85;
    localparam int MAXD_HI_PCT = 75;
    // Longest on-time rounds down
    localparam int MAXON_LO_CYC = PER_LO_CYC * MAXD_LO_PCT / 100;
    localparam int MAXON_HI_CYC = PER_HI_CYC * MAXD_HI_PCT / 100;
    localparam int RETRY_MS = 10;
    localparam int RETRY_CYC = CLK_HZ / 1000 * RETRY_MS;
    localparam int RETRY_W = 17;
    localparam int SYNC_W = 9;

    // ------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATE = 8'h04;
    localparam logic [7:0] REG_INT_STAT = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0C;
    localparam logic [7:0] REG_VARIANT = 8'h10;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [4:0] MASK_RST = 5'h00;
    localparam int INT_OC = 0;
    localparam int INT_UV = 1;
    localparam int INT_OV = 2;
    localparam int INT_PGFALL = 3;
    localparam int INT_SSDONE = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_SOFT    = 7'h02,
        ST_RUN     = 7'h04,
        ST_OCWAIT  = 7'h08,
        ST_OCLATCH = 7'h10,
        ST_UVLATCH = 7'h20,
        ST_OVLATCH = 7'h40
    } bpg_state_t;

    // Digitised comparator and status flags from the pins
    typedef struct packed {
        logic winLow;
        logic winHigh;
        logic uvTrip;
        logic ovTrip;
        logic ovBelowHalf;
        logic ocTrip;
        logic senseOpen;
        logic ssDone;
        logic enable;
    } bpg_flags_t;

    typedef struct packed {
        logic highSide;
        logic lowSide;
    } bpg_gate_t;

endpackage

/* logic/bpg_sync.sv */
// Three-stage pin synchroniser with agreement filter
module bpg_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Chain; first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= asyncIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Output moves only where stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            syncOut <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    syncOut[i] <= s2_r[i];
                end
            end
        end
    end

endmodule

/* logic/bpg_pwm.sv */
// Fixed-period pulse generator with on-time clamp
module bpg_pwm #(
    parameter int PER = 33,
    parameter int MAXON = 28
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [7:0] dutyCmd,
    output logic pwmHigh
);

    localparam logic [7:0] PER_M1 = 8'(PER - 1);
    localparam logic [7:0] MAXON_V = 8'(MAXON);

    logic [7:0] cnt_r;
    logic [7:0] onCnt;

    // Command clamped so the high side never exceeds the duty limit
    assign onCnt = (dutyCmd > MAXON_V) ? MAXON_V : dutyCmd;

    // Period counter, free running; no outside trim
    always_ff @(posedge ref_clk) begin
        if (!rst_n || cnt_r == PER_M1) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pwmHigh <= 1'b0;
        end else begin
            pwmHigh <= run && (cnt_r < onCnt);
        end
    end

    duty_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pwmHigh |-> ($past(cnt_r) < MAXON_V))
        else $error("high side on beyond duty limit");

    period_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cnt_r == PER_M1) |=> (cnt_r == 8'h00))
        else $error("period counter did not wrap");

endmodule

/* tb/bpg_stage_model.sv */
// Behavioural power stage and power-good pull-up seen by the supervisor
module bpg_stage_model #(
    parameter int RAMP = 40
) (
    input wire logic ref_clk,
    input wire logic softStartRun,
    input wire logic powerGoodOut,
    input wire logic powerGoodOe_n,
    output logic softStartDoneIn,
    output logic pgPin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Soft-start ramp
    // ------------------------------------------------------------
    logic [7:0] rampCnt_r;

    // Ramp restarts from zero whenever the supervisor drops the run request
    always_ff @(posedge ref_clk) begin
        if (!softStartRun) begin
            rampCnt_r <= 8'h00;
        end else if (rampCnt_r != 8'(RAMP)) begin
            rampCnt_r <= rampCnt_r + 8'h01;
        end
    end

    // Done falls with run, so each new ramp gives a fresh rising edge
    assign softStartDoneIn = softStartRun && (rampCnt_r == 8'(RAMP));

    // ------------------------------------------------------------
    // Open-drain pin with external pull-up
    // ------------------------------------------------------------
    // Released pin reads high through the resistor, not the last value
    assign pgPin = powerGoodOe_n ? 1'b1 : powerGoodOut;
endmodule

/* tb/buck_fault_and_power_good_logic_tb_top.sv */
// Self-checking bench of the buck fault and power-good supervisor
module buck_fault_and_power_good_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic winLow = 1'b0;
    logic winHigh = 1'b0;
    logic uvTrip = 1'b0;
    logic ovTrip = 1'b0;
    logic belowHalf = 1'b0;
    logic ocTrip = 1'b0;
    logic senseOpen = 1'b0;
    logic ssDone;
    logic enable = 1'b0;
    logic pgOut, pgOe_n, hsDrive, lsDrive, ssRun, irq, pgPin;
    logic hs2, ssRun2;
    logic [31:0] rdData;
    int err_total = 0;
    int samples_checked = 0;

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    bpg_supervisor #(.RETRY_CYCLES(20)) u_bpg_supervisor (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .senseWinLowIn(winLow),
        .senseWinHighIn(winHigh), .undervoltageTripIn(uvTrip),
        .overvoltageTripIn(ovTrip), .senseBelowHalfIn(belowHalf),
        .overcurrentTripIn(ocTrip), .senseOpenIn(senseOpen),
        .softStartDoneIn(ssDone), .enableIn(enable),
        .powerGoodOut(pgOut), .powerGoodOe_n(pgOe_n),
        .highSideDrive(hsDrive), .lowSideDrive(lsDrive),
        .softStartRun(ssRun), .irq(irq)
    );

    bpg_stage_model u_bpg_stage_model (
        .ref_clk(ref_clk), .softStartRun(ssRun), .powerGoodOut(pgOut),
        .powerGoodOe_n(pgOe_n), .softStartDoneIn(ssDone), .pgPin(pgPin)
    );

    // Second build: 600 kHz with overcurrent retry, same pins and bus
    bpg_supervisor #(.FREQ_HIGH(1'b1), .OC_RETRY(1'b1),
        .RETRY_CYCLES(20)) u_bpg_supervisor_retry (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(),
        .senseWinLowIn(winLow), .senseWinHighIn(winHigh),
        .undervoltageTripIn(uvTrip), .overvoltageTripIn(ovTrip),
        .senseBelowHalfIn(belowHalf), .overcurrentTripIn(ocTrip),
        .senseOpenIn(senseOpen), .softStartDoneIn(ssDone),
        .enableIn(enable), .powerGoodOut(), .powerGoodOe_n(),
        .highSideDrive(hs2), .lowSideDrive(), .softStartRun(ssRun2),
        .irq()
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        {winLow, winHigh, uvTrip, ovTrip} <= 4'h0;
        {belowHalf, ocTrip, senseOpen, enable} <= 4'h0;
        cyc(16);
        chk(pgOe_n, 1'b0);
        @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        rdData = regRdata;
    endtask

    task automatic chk_state(input bpg_pkg::bpg_state_t s);
        rd(bpg_pkg::REG_STATE);
        chk({25'h0, rdData[6:0]}, {25'h0, s});
    endtask

    // Bounded wait on the power-good pin level
    task automatic wait_pg(input logic v, input int lim);
        int n;
        n = 0;
        while (pgPin !== v && n < lim) begin
            cyc(1);
            n++;
        end
        if (pgPin !== v) begin
            err_total++;
            $display("[ERR] %0t power-good wait ran out", $time);
            finish_test();
        end
    endtask

    task automatic toggle_enable();
        @(posedge ref_clk);
        enable <= 1'b0;
        repeat (8) @(posedge ref_clk);
        enable <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(bpg_pkg::REG_CTRL);
        chk(rdData, 32'h0000_0000);
        rd(bpg_pkg::REG_INT_MASK);
        chk(rdData, 32'h0000_0000);
        rd(bpg_pkg::REG_VARIANT);
        chk(rdData, 32'h0000_0004);
        rd(8'h20);
        chk(rdData, 32'h0000_0000);
    endtask

    task automatic t_startup();
        @(posedge ref_clk);
        enable <= 1'b1;
        cyc(20);
        chk(pgPin, 1'b0);
        wait_pg(1'b1, 300);
        chk_state(bpg_pkg::ST_RUN);
    endtask

    task automatic t_irq();
        rd(bpg_pkg::REG_INT_STAT);
        chk(rdData[bpg_pkg::INT_SSDONE], 1'b1);
        chk(irq, 1'b0);
        wr(bpg_pkg::REG_INT_MASK, 32'h0000_0010);
        cyc(3);
        chk(irq, 1'b1);
        wr(bpg_pkg::REG_INT_STAT, 32'h0000_0010);
        cyc(3);
        chk(irq, 1'b0);
    endtask

    // Both window edges drop the pin, and it returns once back inside
    task automatic t_window();
        @(posedge ref_clk);
        winLow <= 1'b1;
        wait_pg(1'b0, 10);
        winLow <= 1'b0;
        wait_pg(1'b1, 10);
        winHigh <= 1'b1;
        wait_pg(1'b0, 10);
        winHigh <= 1'b0;
        wait_pg(1'b1, 10);
        rd(bpg_pkg::REG_INT_STAT);
        chk(rdData[bpg_pkg::INT_PGFALL], 1'b1);
    endtask

    // High count over whole periods is phase independent
    task automatic t_pwm(input logic [7:0] cmd, input int expOn,
                         input int expOn2);
        int highs;
        int rises;
        int highs2;
        logic last;
        highs = 0;
        rises = 0;
        highs2 = 0;
        wr(bpg_pkg::REG_CTRL, {24'h0, cmd});
        cyc(2 * bpg_pkg::PER_LO_CYC);
        last = hsDrive;
        repeat (bpg_pkg::PER_LO_CYC * bpg_pkg::PER_HI_CYC) begin
            cyc(1);
            highs += int'(hsDrive === 1'b1);
            highs2 += int'(hs2 === 1'b1);
            rises += int'(hsDrive === 1'b1 && last === 1'b0);
            last = hsDrive;
        end
        chk(highs, bpg_pkg::PER_HI_CYC * expOn);
        chk(rises, bpg_pkg::PER_HI_CYC);
        chk(highs2, bpg_pkg::PER_LO_CYC * expOn2);
    endtask

    task automatic t_oc();
        @(posedge ref_clk);
        ocTrip <= 1'b1;
        cyc(8);
        chk({hsDrive, lsDrive}, 2'b00);
        chk(pgPin, 1'b0);
        ocTrip <= 1'b0;
        cyc(40);
        chk_state(bpg_pkg::ST_OCLATCH);
        chk(ssRun2, 1'b1);
        chk(pgPin, 1'b0);
        toggle_enable();
        wait_pg(1'b1, 300);
    endtask

    task automatic t_uv();
        @(posedge ref_clk);
        uvTrip <= 1'b1;
        cyc(8);
        chk({hsDrive, lsDrive}, 2'b00);
        chk(pgPin, 1'b1);
        uvTrip <= 1'b0;
        toggle_enable();
        cyc(60);
        chk_state(bpg_pkg::ST_UVLATCH);
    endtask

    task automatic t_ov();
        @(posedge ref_clk);
        senseOpen <= 1'b1;
        cyc(8);
        chk({hsDrive, lsDrive}, 2'b01);
        chk(pgPin, 1'b1);
        chk_state(bpg_pkg::ST_OVLATCH);
        senseOpen <= 1'b0;
        belowHalf <= 1'b1;
        cyc(8);
        chk({hsDrive, lsDrive}, 2'b00);
        belowHalf <= 1'b0;
        ovTrip <= 1'b1;
        cyc(8);
        chk({hsDrive, lsDrive}, 2'b01);
        ovTrip <= 1'b0;
        toggle_enable();
        cyc(20);
        chk_state(bpg_pkg::ST_OVLATCH);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        t_regs();
        t_startup();
        t_irq();
        t_window();
        t_pwm(8'hFF, bpg_pkg::MAXON_LO_CYC, bpg_pkg::MAXON_HI_CYC);
        t_pwm(8'h0A, 10, 10);
        t_oc();
        t_uv();
        do_reset();
        t_startup();
        t_ov();
        finish_test();
    end
endmodule
